// >>> hw/smr_regs.sv
// Added by the designer: the AXI4-Lite register port.
`timescale 1ns/100ps
`include "smr_defines.svh"

module smr_regs
  import smr_pkg::*;
#(
  parameter int unsigned TICK_CYCLES = `SMR_TICK_CYCLES
) (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        arst_n,
  // axi4-lite write address and data
  input  wire logic [11:0] s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  // axi4-lite write response
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  // axi4-lite read
  input  wire logic [11:0] s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  // status sources
  input  wire logic [15:0] din,
  input  wire logic [10:0] cond_low,
  input  wire logic [1:0]  app_flag_set,
  input  wire logic [1:0]  app_flag_clr,
  input  wire logic        err_valid,
  input  wire logic [15:0] err_code,
  // target source
  input  wire logic [31:0] ext_target,
  // drive control
  output logic             quickstop,
  output logic             motor_release,
  output logic [15:0]      stop_cfg,
  output logic [31:0]      target_out,
  output logic [15:0]      status_out,
  output logic             irq
);

  localparam logic [31:0] TICK_LAST = 32'(TICK_CYCLES - 1);

  // ****************************************
  // functions
  // ****************************************
  function automatic smr_index_type to_index(input logic [11:0] a);
    return a[10:2];
  endfunction

  function automatic logic mapped(input logic [11:0] a);
    logic hit;
    hit = 1'b0;
    unique case (to_index(a))
      `SMR_IDX_LATCHED, `SMR_IDX_INSEL, `SMR_IDX_QS_MASK, `SMR_IDX_SD_MASK,
      `SMR_IDX_ERROR, `SMR_IDX_STOP_CFG, `SMR_IDX_TIME, `SMR_IDX_TGT_REL,
      `SMR_IDX_TGT_IN, `SMR_IDX_LIVE, `SMR_IDX_IRQ_STAT, `SMR_IDX_IRQ_MASK,
      `SMR_IDX_TGT_SEL: hit = 1'b1;
      default:          hit = 1'b0;
    endcase
    return hit && !a[11] && (a[1:0] == 2'h0);
  endfunction

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] d,
                                        input logic [3:0] strb);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) begin
        r[b*8 +: 8] = d[b*8 +: 8];
      end
    end
    return r;
  endfunction

  // ****************************************
  // state
  // ****************************************
  smr_wr_state_type wr_state, next_wr_state;
  logic [11:0]      awaddr_q, next_awaddr_q;
  logic [31:0]      wdata_q, next_wdata_q;
  logic [3:0]       wstrb_q, next_wstrb_q;
  logic             next_awready, next_wready, next_bvalid, next_arready, next_rvalid;
  logic [1:0]       next_bresp, next_rresp;
  logic [31:0]      next_rdata;

  logic [15:0]      live, next_live;
  logic [15:0]      latched, next_latched;
  logic [15:0]      insel, next_insel;
  logic [15:0]      qs_mask, next_qs_mask;
  logic [15:0]      sd_mask, next_sd_mask;
  logic [15:0]      last_err, next_last_err;
  logic [15:0]      stop_cfg_q, next_stop_cfg_q;
  logic [31:0]      time_cnt, next_time_cnt;
  logic [31:0]      prescale, next_prescale;
  logic [31:0]      tgt_rel, next_tgt_rel;
  logic [31:0]      tgt_in, next_tgt_in;
  smr_tsel_type     tgt_sel, next_tgt_sel;
  logic [1:0]       app_flags, next_app_flags;
  logic [2:0]       irq_stat, next_irq_stat;
  logic [2:0]       irq_mask, next_irq_mask;
  logic             next_quickstop, next_motor_release, next_irq;
  logic [31:0]      next_target_out;

  logic             aw_hs, w_hs, ar_hs, wr_fire;
  logic [11:0]      wa;
  logic [31:0]      wd;
  logic [3:0]       ws;
  logic [31:0]      wm;
  logic             trip_sd, trip_qs, rd_latched;

  smr_filt_if fif ();

  // ****************************************
  // input select and noise filter
  // ****************************************
  assign fif.pins    = din;
  assign fif.sel_one = insel[`SMR_SEL_ONE_LSB +: 4];
  assign fif.sel_two = insel[`SMR_SEL_TWO_LSB +: 4];
  assign fif.delay   = insel[`SMR_FILT_LSB +: 8];

  smr_filter u_filter (
    .clk    (clk),
    .arst_n (arst_n),
    .fb     (fif.filt)
  );

  // ****************************************
  // bus slave
  // ****************************************
  always_comb begin
    aw_hs         = s_axi_awvalid && s_axi_awready;
    w_hs          = s_axi_wvalid && s_axi_wready;
    ar_hs         = s_axi_arvalid && s_axi_arready;
    wa            = aw_hs ? s_axi_awaddr : awaddr_q;
    wd            = w_hs ? s_axi_wdata : wdata_q;
    ws            = w_hs ? s_axi_wstrb : wstrb_q;
    next_awaddr_q = aw_hs ? s_axi_awaddr : awaddr_q;
    next_wdata_q  = w_hs ? s_axi_wdata : wdata_q;
    next_wstrb_q  = w_hs ? s_axi_wstrb : wstrb_q;
    next_wr_state = wr_state;
    next_bvalid   = s_axi_bvalid;
    next_bresp    = s_axi_bresp;
    wr_fire       = 1'b0;
    unique case (wr_state)
      smr_wr_idle: begin
        if (aw_hs && w_hs) begin
          wr_fire = 1'b1;
        end else if (aw_hs) begin
          next_wr_state = smr_wr_addr;
        end else if (w_hs) begin
          next_wr_state = smr_wr_data;
        end
      end
      smr_wr_addr: begin
        wr_fire = w_hs;
      end
      smr_wr_data: begin
        wr_fire = aw_hs;
      end
      smr_wr_resp: begin
        if (s_axi_bready) begin
          next_wr_state = smr_wr_idle;
          next_bvalid   = 1'b0;
        end
      end
    endcase
    if (wr_fire) begin
      next_wr_state = smr_wr_resp;
      next_bvalid   = 1'b1;
      next_bresp    = mapped(wa) ? `SMR_RESP_OKAY : `SMR_RESP_SLVERR;
    end
    next_awready = (next_wr_state == smr_wr_idle) || (next_wr_state == smr_wr_data);
    next_wready  = (next_wr_state == smr_wr_idle) || (next_wr_state == smr_wr_addr);

    next_rvalid = s_axi_rvalid && !s_axi_rready;
    next_rdata  = s_axi_rdata;
    next_rresp  = s_axi_rresp;
    rd_latched  = 1'b0;
    if (ar_hs) begin
      next_rvalid = 1'b1;
      next_rresp  = mapped(s_axi_araddr) ? `SMR_RESP_OKAY : `SMR_RESP_SLVERR;
      next_rdata  = 32'h0000_0000;
      if (mapped(s_axi_araddr)) begin
        unique case (to_index(s_axi_araddr))
          `SMR_IDX_LATCHED: begin
            next_rdata = {16'h0000, latched};
            rd_latched = 1'b1;
          end
          `SMR_IDX_INSEL:    next_rdata = {16'h0000, insel};
          `SMR_IDX_QS_MASK:  next_rdata = {16'h0000, qs_mask};
          `SMR_IDX_SD_MASK:  next_rdata = {16'h0000, sd_mask};
          `SMR_IDX_ERROR:    next_rdata = {16'h0000, last_err};
          `SMR_IDX_STOP_CFG: next_rdata = {16'h0000, stop_cfg_q};
          `SMR_IDX_TIME:     next_rdata = time_cnt;
          `SMR_IDX_TGT_REL:  next_rdata = tgt_rel;
          `SMR_IDX_TGT_IN:   next_rdata = tgt_in;
          `SMR_IDX_LIVE:     next_rdata = {16'h0000, live};
          `SMR_IDX_IRQ_STAT: next_rdata = {29'h0000_0000, irq_stat};
          `SMR_IDX_IRQ_MASK: next_rdata = {29'h0000_0000, irq_mask};
          default:           next_rdata = {29'h0000_0000, tgt_sel};
        endcase
      end
    end
    // one read in flight; a new address is taken only once the data left
    next_arready = !next_rvalid;
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      wr_state      <= smr_wr_idle;
      awaddr_q      <= 12'h000;
      wdata_q       <= `SMR_RST_32;
      wstrb_q       <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= `SMR_RESP_OKAY;
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= `SMR_RST_32;
      s_axi_rresp   <= `SMR_RESP_OKAY;
    end else begin
      wr_state      <= next_wr_state;
      awaddr_q      <= next_awaddr_q;
      wdata_q       <= next_wdata_q;
      wstrb_q       <= next_wstrb_q;
      s_axi_awready <= next_awready;
      s_axi_wready  <= next_wready;
      s_axi_bvalid  <= next_bvalid;
      s_axi_bresp   <= next_bresp;
      s_axi_arready <= next_arready;
      s_axi_rvalid  <= next_rvalid;
      s_axi_rdata   <= next_rdata;
      s_axi_rresp   <= next_rresp;
    end
  end

  // ****************************************
  // register file and drive logic
  // ****************************************
  always_comb begin
    wm                 = 32'h0000_0000;
    next_insel         = insel;
    next_qs_mask       = qs_mask;
    next_sd_mask       = sd_mask;
    next_stop_cfg_q    = stop_cfg_q;
    next_tgt_rel       = tgt_rel;
    next_tgt_in        = tgt_in;
    next_tgt_sel       = tgt_sel;
    next_irq_mask      = irq_mask;
    next_irq_stat      = irq_stat;
    next_last_err      = last_err;
    next_time_cnt      = time_cnt;
    next_prescale      = prescale + 32'h0000_0001;

    // time base wraps naturally at 2^32 ticks
    if (prescale >= TICK_LAST) begin
      next_prescale = 32'h0000_0000;
      next_time_cnt = time_cnt + 32'h0000_0001;
    end

    if (wr_fire && mapped(wa)) begin
      unique case (to_index(wa))
        `SMR_IDX_INSEL:    next_insel      = 16'(merge({16'h0000, insel}, wd, ws));
        `SMR_IDX_QS_MASK:  next_qs_mask    = 16'(merge({16'h0000, qs_mask}, wd, ws));
        `SMR_IDX_SD_MASK:  next_sd_mask    = 16'(merge({16'h0000, sd_mask}, wd, ws));
        `SMR_IDX_STOP_CFG: next_stop_cfg_q = 16'(merge({16'h0000, stop_cfg_q}, wd, ws));
        `SMR_IDX_TIME: begin
          next_time_cnt = merge(time_cnt, wd, ws);
          next_prescale = 32'h0000_0000;
        end
        `SMR_IDX_TGT_REL: begin
          wm           = merge(32'h0000_0000, wd, ws);
          next_tgt_rel = wm;
          next_tgt_in  = tgt_in + wm;
        end
        `SMR_IDX_TGT_IN:   next_tgt_in   = merge(tgt_in, wd, ws);
        `SMR_IDX_IRQ_STAT: next_irq_stat = irq_stat & ~wd[2:0];
        `SMR_IDX_IRQ_MASK: next_irq_mask = wd[2:0];
        `SMR_IDX_TGT_SEL: begin
          if (wd[2:0] <= 3'h6) begin
            next_tgt_sel = smr_tsel_type'(wd[2:0]);
          end
        end
        default: begin
        end
      endcase
    end

    // read-only registers ignore writes; a new error overwrites the old code
    if (err_valid) begin
      next_last_err = err_code;
    end

    next_app_flags = (app_flags & ~app_flag_clr) | app_flag_set;

    next_live                   = {5'h00, cond_low};
    next_live[`SMR_BIT_PIN_ONE] = fif.flt[0];
    next_live[`SMR_BIT_PIN_TWO] = fif.flt[1];
    next_live[`SMR_BIT_APP_ONE] = app_flags[0];
    next_live[`SMR_BIT_APP_TWO] = app_flags[1];

    // a read clears the copy, but a live bit in that cycle sets it again
    next_latched = (rd_latched ? 16'h0000 : latched) | live;

    trip_sd            = |(live & sd_mask);
    trip_qs            = |(live & qs_mask) && !trip_sd;
    next_motor_release = trip_sd;
    next_quickstop     = trip_qs;

    // events set after clears so a same-cycle event is kept
    if (trip_qs && !quickstop) begin
      next_irq_stat[`SMR_IRQ_QSTOP] = 1'b1;
    end
    if (trip_sd && !motor_release) begin
      next_irq_stat[`SMR_IRQ_SDOWN] = 1'b1;
    end
    if (err_valid) begin
      next_irq_stat[`SMR_IRQ_ERROR] = 1'b1;
    end
    next_irq = |(next_irq_stat & next_irq_mask);

    next_target_out = (tgt_sel == smr_tsel_register) ? tgt_in : ext_target;
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      live          <= `SMR_RST_16;
      latched       <= `SMR_RST_16;
      insel         <= `SMR_RST_16;
      qs_mask       <= `SMR_RST_16;
      sd_mask       <= `SMR_RST_16;
      last_err      <= `SMR_RST_16;
      stop_cfg_q    <= `SMR_RST_16;
      time_cnt      <= `SMR_RST_32;
      prescale      <= `SMR_RST_32;
      tgt_rel       <= `SMR_RST_32;
      tgt_in        <= `SMR_RST_32;
      tgt_sel       <= smr_tsel_register;
      app_flags     <= 2'h0;
      irq_stat      <= `SMR_RST_IRQ;
      irq_mask      <= `SMR_RST_IRQ;
      quickstop     <= 1'b0;
      motor_release <= 1'b0;
      irq           <= 1'b0;
      target_out    <= `SMR_RST_32;
      stop_cfg      <= `SMR_RST_16;
      status_out    <= `SMR_RST_16;
    end else begin
      live          <= next_live;
      latched       <= next_latched;
      insel         <= next_insel;
      qs_mask       <= next_qs_mask;
      sd_mask       <= next_sd_mask;
      last_err      <= next_last_err;
      stop_cfg_q    <= next_stop_cfg_q;
      time_cnt      <= next_time_cnt;
      prescale      <= next_prescale;
      tgt_rel       <= next_tgt_rel;
      tgt_in        <= next_tgt_in;
      tgt_sel       <= next_tgt_sel;
      app_flags     <= next_app_flags;
      irq_stat      <= next_irq_stat;
      irq_mask      <= next_irq_mask;
      quickstop     <= next_quickstop;
      motor_release <= next_motor_release;
      irq           <= next_irq;
      target_out    <= next_target_out;
      stop_cfg      <= next_stop_cfg_q;
      status_out    <= next_live;
    end
  end

endmodule

// >>> hw/smr_defines.svh
`ifndef SMR_DEFINES_SVH
`define SMR_DEFINES_SVH

// ****************************************
// register indices, byte address is four times the index
// ****************************************
`define SMR_IDX_LATCHED   9'h19b
`define SMR_IDX_INSEL     9'h19c
`define SMR_IDX_QS_MASK   9'h19d
`define SMR_IDX_SD_MASK   9'h19e
`define SMR_IDX_ERROR     9'h19f
`define SMR_IDX_STOP_CFG  9'h1a0
`define SMR_IDX_TIME      9'h1a4
`define SMR_IDX_TGT_REL   9'h1c0
`define SMR_IDX_TGT_IN    9'h1c2
`define SMR_IDX_LIVE      9'h1d0
`define SMR_IDX_IRQ_STAT  9'h1d1
`define SMR_IDX_IRQ_MASK  9'h1d2
`define SMR_IDX_TGT_SEL   9'h1d3

// ****************************************
// field positions
// ****************************************
`define SMR_BIT_PIN_ONE   12
`define SMR_BIT_PIN_TWO   13
`define SMR_BIT_APP_ONE   14
`define SMR_BIT_APP_TWO   15
`define SMR_SEL_ONE_LSB   0
`define SMR_SEL_TWO_LSB   4
`define SMR_FILT_LSB      8
`define SMR_IRQ_QSTOP     0
`define SMR_IRQ_SDOWN     1
`define SMR_IRQ_ERROR     2

// ****************************************
// reset values and responses
// ****************************************
`define SMR_RST_16        16'h0000
`define SMR_RST_32        32'h0000_0000
`define SMR_RST_IRQ       3'h0
`define SMR_RESP_OKAY     2'h0
`define SMR_RESP_SLVERR   2'h2

// ****************************************
// timing
// ****************************************
`define SMR_CLK_HZ        200000000
`define SMR_TICK_HZ       4000
`define SMR_TICK_CYCLES   (`SMR_CLK_HZ / `SMR_TICK_HZ)
`define SMR_FILT_STEP_NS  80
`define SMR_FILT_STEP_CYC ((`SMR_FILT_STEP_NS * (`SMR_CLK_HZ / 1000000)) / 1000)

`endif

// >>> hw/smr_pkg.sv
package smr_pkg;

  typedef enum logic [1:0] {
    smr_wr_idle = 2'h0,
    smr_wr_addr = 2'h1,
    smr_wr_resp = 2'h3,
    smr_wr_data = 2'h2
  } smr_wr_state_type;

  typedef enum logic [2:0] {
    smr_tsel_register = 3'h0,
    smr_tsel_analog1  = 3'h1,
    smr_tsel_analog2  = 3'h2,
    smr_tsel_analog3  = 3'h3,
    smr_tsel_analog4  = 3'h4,
    smr_tsel_encoder  = 3'h5,
    smr_tsel_pulse    = 3'h6
  } smr_tsel_type;

  typedef logic [8:0] smr_index_type;

endpackage

// >>> hw/smr_filt_if.sv
`timescale 1ns/100ps

interface smr_filt_if;
  logic [15:0] pins;
  logic [3:0]  sel_one;
  logic [3:0]  sel_two;
  logic [7:0]  delay;
  logic [1:0]  flt;

  modport ctrl (output pins, output sel_one, output sel_two, output delay, input flt);
  modport filt (input pins, input sel_one, input sel_two, input delay, output flt);
endinterface

// >>> hw/smr_filter.sv
`timescale 1ns/100ps
`include "smr_defines.svh"

module smr_filter
  import smr_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // selection and result
  smr_filt_if.filt fb
);

  localparam logic [11:0] STEP = 12'(`SMR_FILT_STEP_CYC);

  logic [11:0] cnt      [2];
  logic [11:0] next_cnt [2];
  logic [1:0]  flt;
  logic [1:0]  next_flt;
  logic [1:0]  raw;
  logic [11:0] limit;

  // a change must stay stable for delay*step+1 cycles before it shows
  always_comb begin
    limit    = 12'(fb.delay * STEP);
    raw[0]   = fb.pins[fb.sel_one];
    raw[1]   = fb.pins[fb.sel_two];
    next_flt = flt;
    for (int i = 0; i < 2; i++) begin
      next_cnt[i] = 12'h000;
      if (raw[i] != flt[i]) begin
        if (cnt[i] >= limit) begin
          next_flt[i] = raw[i];
        end else begin
          next_cnt[i] = cnt[i] + 12'h001;
        end
      end
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      flt    <= 2'h0;
      cnt[0] <= 12'h000;
      cnt[1] <= 12'h000;
    end else begin
      flt    <= next_flt;
      cnt[0] <= next_cnt[0];
      cnt[1] <= next_cnt[1];
    end
  end

  assign fb.flt = flt;

endmodule

// >>> tb/smr_regs_sva.sv
`timescale 1ns/100ps

module smr_regs_sva #(
  parameter int unsigned TICK_CYCLES = 4
) (
  // clock and reset
  input wire logic        clk,
  input wire logic        arst_n,
  // register bus
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic        s_axi_bvalid,
  input wire logic [11:0] s_axi_araddr,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0]  s_axi_rresp,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  // status and drive
  input wire logic [10:0] cond_low,
  input wire logic [1:0]  app_flag_set,
  input wire logic [1:0]  app_flag_clr,
  input wire logic        quickstop,
  input wire logic        motor_release,
  input wire logic [15:0] status_out
);
  // ****************************************
  // checks
  // ****************************************
  default clocking @(posedge clk); endclocking
  default disable iff (!arst_n);

  // first edge after reset still sees reset-time inputs
  a_live_follow: assert property ($past(arst_n) |-> status_out[10:0] == $past(cond_low) && !status_out[11])
    else $error("live status does not follow conditions");
  // flag register plus live register: two edges from event to status
  a_app_set: assert property (app_flag_set[0] |-> ##2 status_out[14])
    else $error("user flag not set");
  a_app_source: assert property ($rose(status_out[15]) |-> $past(app_flag_set[1], 2))
    else $error("user flag set without event");
  a_app_clear: assert property (app_flag_clr[1] && !app_flag_set[1] |-> ##2 !status_out[15])
    else $error("user flag not cleared");
  a_stop_exclusive: assert property (!(quickstop && motor_release))
    else $error("quickstop and release together");
  a_release_cause: assert property (motor_release |-> $past(status_out) != 16'h0000)
    else $error("release without status");
  a_quick_cause: assert property (quickstop |-> $past(status_out) != 16'h0000)
    else $error("quickstop without status");
  a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  a_read_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped");
  a_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |=> s_axi_bvalid)
    else $error("write answer late");
  a_unmapped_read: assert property (s_axi_arvalid && s_axi_arready
    && (s_axi_araddr[11] || s_axi_araddr[1:0] != 2'h0)
    |=> s_axi_rresp == 2'h2 && s_axi_rdata == 32'h0000_0000)
    else $error("unmapped read not refused");
endmodule

bind smr_regs smr_regs_sva #(.TICK_CYCLES(TICK_CYCLES)) u_sva (
  .clk(clk), .arst_n(arst_n), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
  .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bvalid(s_axi_bvalid),
  .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
  .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
  .s_axi_rready(s_axi_rready), .cond_low(cond_low), .app_flag_set(app_flag_set),
  .app_flag_clr(app_flag_clr), .quickstop(quickstop), .motor_release(motor_release),
  .status_out(status_out));

// >>> tb/tb_top.sv
`timescale 1ns/100ps
`include "smr_defines.svh"

module tb_top;
  import smr_pkg::*;
  // ****************************************
  // signals
  // ****************************************
  localparam int unsigned TICK = 200;
  logic        clk = 1'b0;
  logic        arst_n, awvalid, wvalid, bready, arvalid, rready, err_valid;
  logic        awready, wready, bvalid, arready, rvalid, quickstop, motor_release, irq;
  logic [1:0]  bresp, rresp, app_set, app_clr;
  logic [3:0]  wstrb;
  logic [10:0] cond_low;
  logic [11:0] awaddr, araddr;
  logic [15:0] din, err_code, stop_cfg, status_out;
  logic [31:0] wdata, rdata, ext_target, target_out, v, t, r;
  logic [34:0] notes[$];
  int          mismatches, compares, cycles;
  smr_index_type zero_regs[12] = '{`SMR_IDX_LATCHED, `SMR_IDX_INSEL, `SMR_IDX_QS_MASK, `SMR_IDX_SD_MASK,
    `SMR_IDX_ERROR, `SMR_IDX_STOP_CFG, `SMR_IDX_TGT_REL, `SMR_IDX_TGT_IN, `SMR_IDX_LIVE,
    `SMR_IDX_IRQ_STAT, `SMR_IDX_IRQ_MASK, `SMR_IDX_TGT_SEL};
  smr_index_type rw_regs[4] = '{`SMR_IDX_INSEL, `SMR_IDX_QS_MASK, `SMR_IDX_SD_MASK, `SMR_IDX_STOP_CFG};
  logic [3:0]  pin_a[2] = '{4'h3, 4'hf};
  logic [3:0]  pin_b[2] = '{4'h9, 4'h0};

  always #2.5 clk = ~clk;

  smr_regs #(.TICK_CYCLES(TICK)) uut (
    .clk(clk), .arst_n(arst_n), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready), .din(din), .cond_low(cond_low), .app_flag_set(app_set),
    .app_flag_clr(app_clr), .err_valid(err_valid), .err_code(err_code), .ext_target(ext_target),
    .quickstop(quickstop), .motor_release(motor_release), .stop_cfg(stop_cfg), .target_out(target_out),
    .status_out(status_out), .irq(irq));

  // ****************************************
  // tasks
  // ****************************************
  task automatic report_and_stop();
    if (mismatches == 0 && compares > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      mismatches++;
      $display("Error at %0t: got %h, expected %h", $time, got, exp);
    end
  endtask

  function automatic logic [11:0] ad(input smr_index_type i);
    return {1'b0, i, 2'b00};
  endfunction

  task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] e = 2'h0,
                    input logic [3:0] s = 4'hf);
    logic ta, tw;
    ta = 1'b0;
    tw = 1'b0;
    notes.push_back({1'b1, e, 32'h0});
    @(posedge clk);
    awaddr <= a;
    wdata <= d;
    wstrb <= s;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    // address and data may be taken at different edges
    while (!(ta && tw)) begin
      @(posedge clk);
      if (awready && !ta) begin
        ta = 1'b1;
        awvalid <= 1'b0;
      end
      if (wready && !tw) begin
        tw = 1'b1;
        wvalid <= 1'b0;
      end
    end
    do @(posedge clk); while (bvalid !== 1'b1);
    bready <= 1'b0;
  endtask

  task automatic rd(input logic [11:0] a, input logic [31:0] d, input logic [1:0] e = 2'h0);
    notes.push_back({1'b0, e, d});
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(posedge clk); while (arready !== 1'b1);
    arvalid <= 1'b0;
    do @(posedge clk); while (rvalid !== 1'b1);
    rready <= 1'b0;
  endtask

  task automatic take(input logic [34:0] got);
    compares++;
    if (notes.size() == 0 || got !== notes[0]) begin
      mismatches++;
      $display("Error at %0t: bus answer %h unexpected", $time, got);
    end
    if (notes.size() != 0) void'(notes.pop_front());
  endtask

  // ****************************************
  // monitor and timeout
  // ****************************************
  always @(posedge clk) begin
    if (bvalid === 1'b1 && bready) take({1'b1, bresp, 32'h0});
    if (rvalid === 1'b1 && rready) take({1'b0, rresp, rdata});
    cycles++;
    if (cycles == 6000) begin
      mismatches++;
      report_and_stop();
    end
  end

  // ****************************************
  // scenarios
  // ****************************************
  initial begin
    void'($urandom(31764));
    {arst_n, awvalid, wvalid, bready, arvalid, rready, err_valid} = 7'h00;
    {awaddr, araddr, wdata, wstrb, din, cond_low, app_set, app_clr, err_code, ext_target} = '0;
    repeat (20) @(posedge clk);
    arst_n <= 1'b1;
    repeat (2) @(posedge clk);
    foreach (zero_regs[i]) rd(ad(zero_regs[i]), 32'h0);
    foreach (rw_regs[i]) begin
      v = $urandom;
      wr(ad(rw_regs[i]), v);
      rd(ad(rw_regs[i]), {16'h0, v[15:0]});
    end
    check(32'(stop_cfg), {16'h0, v[15:0]});
    wr(ad(`SMR_IDX_STOP_CFG), 32'h0000_a5a5, 2'h0, 4'h1);
    rd(ad(`SMR_IDX_STOP_CFG), {16'h0, v[15:8], 8'ha5});
    foreach (rw_regs[i]) wr(ad(rw_regs[i]), 32'h0);
    wr(ad(`SMR_IDX_ERROR), 32'hffff);
    rd(ad(`SMR_IDX_ERROR), 32'h0);
    wr(12'h800, 32'h1, 2'h2);
    rd(12'h66d, 32'h0, 2'h2);
    v = $urandom;
    cond_low <= v[10:0];
    repeat (3) @(posedge clk);
    check(32'(status_out), 32'(v[10:0]));
    rd(ad(`SMR_IDX_LIVE), 32'(v[10:0]));
    cond_low <= 11'h000;
    rd(ad(`SMR_IDX_LATCHED), 32'(v[10:0]));
    rd(ad(`SMR_IDX_LATCHED), 32'h0);
    app_set <= 2'b11;
    @(posedge clk);
    app_set <= 2'b00;
    repeat (3) @(posedge clk);
    check(32'(status_out), 32'hc000);
    app_set <= 2'b01;
    app_clr <= 2'b11;
    @(posedge clk);
    {app_set, app_clr} <= 4'h0;
    repeat (3) @(posedge clk);
    check(32'(status_out), 32'h4000);
    foreach (pin_a[i]) begin
      wr(ad(`SMR_IDX_INSEL), {24'h0, pin_b[i], pin_a[i]});
      din <= 16'h1 << pin_a[i];
      repeat (5) @(posedge clk);
      check(32'(status_out[13:12]), 32'h1);
      din <= 16'h1 << pin_b[i];
      repeat (5) @(posedge clk);
      check(32'(status_out[13:12]), 32'h2);
    end
    // a 24-cycle pulse passes a 16-cycle filter but not a 32-cycle one
    for (int k = 1; k <= 2; k++) begin
      wr(ad(`SMR_IDX_INSEL), 32'(k << 8));
      din <= 16'h0001;
      repeat (24) @(posedge clk);
      check(32'(status_out[12]), 32'(k == 1));
      din <= 16'h0000;
      repeat (60) @(posedge clk);
    end
    wr(ad(`SMR_IDX_QS_MASK), 32'h9);
    wr(ad(`SMR_IDX_SD_MASK), 32'h8);
    cond_low <= 11'h001;
    repeat (4) @(posedge clk);
    check(32'({quickstop, motor_release}), 32'h2);
    cond_low <= 11'h009;
    repeat (4) @(posedge clk);
    check(32'({quickstop, motor_release}), 32'h1);
    cond_low <= 11'h000;
    repeat (4) @(posedge clk);
    check(32'({quickstop, motor_release, irq}), 32'h0);
    wr(ad(`SMR_IDX_IRQ_MASK), 32'h3);
    repeat (2) @(posedge clk);
    check(32'(irq), 32'h1);
    wr(ad(`SMR_IDX_IRQ_STAT), 32'h3);
    repeat (2) @(posedge clk);
    check(32'(irq), 32'h0);
    v = $urandom;
    err_valid <= 1'b1;
    err_code <= v[15:0];
    @(posedge clk);
    err_code <= v[31:16];
    @(posedge clk);
    err_valid <= 1'b0;
    rd(ad(`SMR_IDX_ERROR), 32'(v[31:16]));
    rd(ad(`SMR_IDX_IRQ_STAT), 32'h4);
    check(32'(irq), 32'h0);
    t = $urandom;
    r = $urandom;
    wr(ad(`SMR_IDX_TGT_IN), t);
    wr(ad(`SMR_IDX_TGT_REL), r);
    rd(ad(`SMR_IDX_TGT_IN), t + r);
    check(target_out, t + r);
    v = $urandom;
    ext_target <= v;
    wr(ad(`SMR_IDX_TGT_SEL), 32'h1);
    repeat (2) @(posedge clk);
    check(target_out, v);
    wr(ad(`SMR_IDX_TIME), 32'hffff_ffff);
    rd(ad(`SMR_IDX_TIME), 32'hffff_ffff);
    repeat (TICK) @(posedge clk);
    rd(ad(`SMR_IDX_TIME), 32'h0);
    repeat (5) @(posedge clk);
    check(32'(notes.size()), 32'h0);
    report_and_stop();
  end
endmodule
